// ### atrt_defines.svh
// Summary of operation
// - Capture flag sets on capture, clears on reading either capture byte.
// - Capture interrupt requested only while capture interrupt enable is one.
// - Clock select 00/11 stops counter one, 01 lite tick, 10 CPU clock.
// - Counter one overflow sets flag; status read clears; gated by its enable.
// - One compare interrupt enable gates all four compare flags; resets zero.
// - Counter one counts up per tick, reloads after overflow, resets zero.
// - Reload value one is loaded at each overflow and sets PWM period.
// - Output enable bits route PWM to pins; zero frees the pin; reset zero.
// - Polarity bit zero passes the waveform, one inverts it; resets zero.
// - Compare flag sets when counter one equals nonzero active duty, channels 2/3 only with counter two run bit zero; channel status read clears.
// - Break active is software read/write, set by low break pin if enabled.
// - During break the four outputs show the break pattern bits.
// - Top two bits of break control and status two read as zero.
// - Duty value sets both the PWM duty cycle and the compare value.
// - Capture pin edge copies counter one into capture value if flag clear.
// - Capture source select picks own pin at zero, lite pin at one.
// - Counter two wrap from maximum sets its flag; status two read clears.
// - Counter two run bit starts counter two; outputs three, four follow it.
// - Transfer two set at reset; copies channel 2/3 preloads at wrap, clears.
// - Transfer one likewise for counter one overflow; cleared after transfer.
`ifndef ATRT_DEFINES_SVH
`define ATRT_DEFINES_SVH

// Register offsets
`define ATRT_OFS_CSR     6'h0d
`define ATRT_OFS_CNT1H   6'h0e
`define ATRT_OFS_CNT1L   6'h0f
`define ATRT_OFS_RLD1H   6'h10
`define ATRT_OFS_RLD1L   6'h11
`define ATRT_OFS_OE      6'h12
`define ATRT_OFS_CH0CSR  6'h13
`define ATRT_OFS_DUTY0H  6'h17
`define ATRT_OFS_CAPH    6'h1f
`define ATRT_OFS_CAPL    6'h20
`define ATRT_OFS_CSR2    6'h21
`define ATRT_OFS_BRK     6'h22
`define ATRT_OFS_RLD2H   6'h23
`define ATRT_OFS_RLD2L   6'h24

// Control status register fields
`define ATRT_CSR_ICF     6
`define ATRT_CSR_CAPTURE_IRQ_ENABLE    5
`define ATRT_CSR_CK_HI   4
`define ATRT_CSR_CK_LO   3
`define ATRT_CSR_FIRST_OVERFLOW_FLAG    2
`define ATRT_CSR_FIRST_OVERFLOW_IRQ_ENABLE  1
`define ATRT_CSR_COMPARE_IRQ_ENABLE   0

// Clock select codes
`define ATRT_CK_LITE     2'h1
`define ATRT_CK_CPU      2'h2

// Status two fields
`define ATRT_CSR2_ICS    5
`define ATRT_CSR2_SECOND_OVERFLOW_IRQ_ENABLE 4
`define ATRT_CSR2_SECOND_OVERFLOW_FLAG   3
`define ATRT_CSR2_RUN2   2
`define ATRT_CSR2_SECOND_TRANSFER_ENABLE  1
`define ATRT_CSR2_FIRST_TRANSFER_ENABLE  0
`define ATRT_CSR2_RESET  8'h03

// Break control fields
`define ATRT_BRK_BA      5
`define ATRT_BRK_BREAK_PIN_ENABLE    4

// Channel status fields
`define ATRT_CH_POL      1
`define ATRT_CH_CMPF     0

// Counter limits
`define ATRT_CNT_MAX     12'hfff
`define ATRT_CNT_ZERO    12'h000

`endif

// ### atrt_pkg.sv
package atrt_pkg;
   typedef logic [5:0] atrt_addr_t;
   typedef logic [7:0] atrt_byte_t;
   typedef logic [11:0] atrt_cnt_t;

   // Counter state
   typedef struct packed {
      logic [11:0] cnt;
   } atrt_ctr_t;

   // Channel waveform state
   typedef struct packed {
      logic level;
   } atrt_chan_t;

   // Register and output state of the timer, apart from counter and channel state
   typedef struct packed {
      logic capture_flag;
      logic capture_irq_enable;
      logic [1:0] ck;
      logic first_overflow_flag;
      logic first_overflow_irq_enable;
      logic compare_irq_enable;
      logic [11:0] rld1;
      logic [11:0] rld2;
      logic [3:0] oe;
      logic [3:0] pol_pre;
      logic [3:0] pol_act;
      logic [3:0] cmpf;
      logic [3:0][11:0] duty_pre;
      logic [3:0][11:0] duty_act;
      logic ba;
      logic break_pin_enable;
      logic [3:0] pattern;
      logic [11:0] cap;
      logic capture_source_select;
      logic second_overflow_irq_enable;
      logic second_overflow_flag;
      logic run2;
      logic second_transfer_enable;
      logic first_transfer_enable;
      logic [3:0] hi_hold;
      logic cap_prev;
      logic [7:0] rd_data;
      logic irq_cap_cmp;
      logic irq_first_overflow_flag;
      logic irq_second_overflow_flag;
      logic [3:0] pwm;
      logic [3:0] pwm_oe;
   } atrt_regs_t;
endpackage

// ### atrt_counter.sv
`timescale 1ns/1ps
`include "atrt_defines.svh"
module atrt_counter (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire logic clear_i,
   input wire atrt_pkg::atrt_cnt_t reload_i,
   output atrt_pkg::atrt_cnt_t cnt_o,
   output atrt_pkg::atrt_cnt_t next_cnt_o,
   output logic wrap_o
);
   import atrt_pkg::*;

   atrt_ctr_t q;
   atrt_ctr_t next_q;

   // Wrap from the maximum count reloads rather than rolling to zero
   always_comb begin
      next_q = q;
      wrap_o = tick_i && (q.cnt == `ATRT_CNT_MAX);
      if (clear_i) begin
         next_q.cnt = `ATRT_CNT_ZERO;
      end else if (wrap_o) begin
         next_q.cnt = reload_i;
      end else if (tick_i) begin
         next_q.cnt = q.cnt + 12'h001;
      end
   end

   assign cnt_o = q.cnt;
   assign next_cnt_o = next_q.cnt;

   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= next_q;
      end
   end
endmodule

// ### atrt_channel.sv
`timescale 1ns/1ps
`include "atrt_defines.svh"
module atrt_channel (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire logic wrap_i,
   input wire logic clear_i,
   input wire atrt_pkg::atrt_cnt_t next_cnt_i,
   input wire atrt_pkg::atrt_cnt_t duty_i,
   output logic level_o
);
   import atrt_pkg::*;

   atrt_chan_t q;
   atrt_chan_t next_q;

   // High from reload, low from duty match; match checked last so a duty
   // equal to the reload value gives a flat low output
   always_comb begin
      next_q = q;
      if (clear_i) begin
         next_q.level = 1'b0;
      end else begin
         if (wrap_i) begin
            next_q.level = 1'b1;
         end
         if (tick_i && (next_cnt_i == duty_i)) begin
            next_q.level = 1'b0;
         end
      end
   end

   assign level_o = q.level;

   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= next_q;
      end
   end
endmodule

// ### atrt_timer.sv
`timescale 1ns/1ps
`include "atrt_defines.svh"
module atrt_timer (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire atrt_pkg::atrt_addr_t addr_i,
   input wire atrt_pkg::atrt_byte_t wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic lite_timer_tick_i,
   input wire logic own_capture_pin_i,
   input wire logic lite_capture_pin_i,
   input wire logic break_pin_b_i,
   output atrt_pkg::atrt_byte_t rd_data_o,
   output logic [3:0] pwm_o,
   output logic [3:0] pwm_oe_o,
   output logic irq_capture_compare_o,
   output logic irq_overflow_one_o,
   output logic irq_overflow_two_o
);
   import atrt_pkg::*;

   atrt_regs_t q;
   atrt_regs_t next_q;

   atrt_cnt_t cnt1;
   atrt_cnt_t cnt2;
   atrt_cnt_t next_cnt1;
   atrt_cnt_t next_cnt2;
   logic wrap1;
   logic wrap2;
   logic tick1;
   logic tick2;
   logic [3:0] level;
   logic [3:0] ch_tick;
   logic [3:0] ch_wrap;
   atrt_cnt_t ch_next [4];
   logic cap_sel;
   logic cap_edge;

   // Twelve-bit value split into its two readable bytes
   function automatic atrt_byte_t hi_byte(input atrt_cnt_t v);
      hi_byte = {4'h0, v[11:8]};
   endfunction

   function automatic atrt_byte_t lo_byte(input atrt_cnt_t v);
      lo_byte = v[7:0];
   endfunction

   // Counter one tick; break stops both counters
   always_comb begin
      unique case (q.ck)
         `ATRT_CK_LITE: tick1 = lite_timer_tick_i;
         `ATRT_CK_CPU: tick1 = 1'b1;
         default: tick1 = 1'b0;
      endcase
      if (q.ba) begin
         tick1 = 1'b0;
      end
   end

   // Counter two shares the selected tick and runs only when enabled
   assign tick2 = tick1 && q.run2;

   atrt_counter u_cnt1 (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .tick_i(tick1),
      .clear_i(q.ba),
      .reload_i(q.rld1),
      .cnt_o(cnt1),
      .next_cnt_o(next_cnt1),
      .wrap_o(wrap1)
   );

   atrt_counter u_cnt2 (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .tick_i(tick2),
      .clear_i(q.ba),
      .reload_i(q.rld2),
      .cnt_o(cnt2),
      .next_cnt_o(next_cnt2),
      .wrap_o(wrap2)
   );

   // Channels two and three move to counter two in dual mode
   generate
      for (genvar i = 0; i < 4; i++) begin : g_ch
         if (i >= 2) begin : g_hi
            assign ch_tick[i] = q.run2 ? tick2 : tick1;
            assign ch_wrap[i] = q.run2 ? wrap2 : wrap1;
            assign ch_next[i] = q.run2 ? next_cnt2 : next_cnt1;
         end else begin : g_lo
            assign ch_tick[i] = tick1;
            assign ch_wrap[i] = wrap1;
            assign ch_next[i] = next_cnt1;
         end
         atrt_channel u_ch (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .ce_i(ce_i),
            .tick_i(ch_tick[i]),
            .wrap_i(ch_wrap[i]),
            .clear_i(q.ba),
            .next_cnt_i(ch_next[i]),
            .duty_i(q.duty_act[i]),
            .level_o(level[i])
         );
      end
   endgenerate

   // Capture trigger; a source switch can itself look like an edge
   assign cap_sel = q.capture_source_select ? lite_capture_pin_i : own_capture_pin_i;
   assign cap_edge = cap_sel ^ q.cap_prev;

   // Register writes, hardware events and read data
   always_comb begin
      next_q = q;
      next_q.rd_data = 8'h00;
      next_q.cap_prev = cap_sel;

      // Software writes; flags are not writable
      if (wr_i) begin
         unique case (addr_i)
            `ATRT_OFS_CSR: begin
               next_q.capture_irq_enable = wr_data_i[`ATRT_CSR_CAPTURE_IRQ_ENABLE];
               next_q.ck = wr_data_i[`ATRT_CSR_CK_HI:`ATRT_CSR_CK_LO];
               next_q.first_overflow_irq_enable = wr_data_i[`ATRT_CSR_FIRST_OVERFLOW_IRQ_ENABLE];
               next_q.compare_irq_enable = wr_data_i[`ATRT_CSR_COMPARE_IRQ_ENABLE];
            end
            `ATRT_OFS_RLD1H: next_q.rld1[11:8] = wr_data_i[3:0];
            `ATRT_OFS_RLD1L: next_q.rld1[7:0] = wr_data_i;
            `ATRT_OFS_RLD2H: next_q.rld2[11:8] = wr_data_i[3:0];
            `ATRT_OFS_RLD2L: next_q.rld2[7:0] = wr_data_i;
            `ATRT_OFS_OE: begin
               for (int i = 0; i < 4; i++) begin
                  next_q.oe[i] = wr_data_i[2 * i];
               end
            end
            `ATRT_OFS_CSR2: begin
               next_q.capture_source_select = wr_data_i[`ATRT_CSR2_ICS];
               next_q.second_overflow_irq_enable = wr_data_i[`ATRT_CSR2_SECOND_OVERFLOW_IRQ_ENABLE];
               next_q.run2 = wr_data_i[`ATRT_CSR2_RUN2];
               next_q.second_transfer_enable = wr_data_i[`ATRT_CSR2_SECOND_TRANSFER_ENABLE];
               next_q.first_transfer_enable = wr_data_i[`ATRT_CSR2_FIRST_TRANSFER_ENABLE];
            end
            `ATRT_OFS_BRK: begin
               next_q.ba = wr_data_i[`ATRT_BRK_BA];
               next_q.break_pin_enable = wr_data_i[`ATRT_BRK_BREAK_PIN_ENABLE];
               next_q.pattern = wr_data_i[3:0];
            end
            default: begin
            end
         endcase
         // Channel status bytes sit in a run of four, duty bytes in a run of eight
         for (int i = 0; i < 4; i++) begin
            if (addr_i == `ATRT_OFS_CH0CSR + 6'(i)) begin
               next_q.pol_pre[i] = wr_data_i[`ATRT_CH_POL];
            end
            if (addr_i == `ATRT_OFS_DUTY0H + 6'(2 * i)) begin
               next_q.duty_pre[i][11:8] = wr_data_i[3:0];
            end
            if (addr_i == `ATRT_OFS_DUTY0H + 6'(2 * i + 1)) begin
               next_q.duty_pre[i][7:0] = wr_data_i;
            end
         end
      end

      // Reads; clear-on-read flags drop here and may be set again below
      if (rd_i) begin
         unique case (addr_i)
            `ATRT_OFS_CSR: begin
               next_q.rd_data = {1'b0, q.capture_flag, q.capture_irq_enable, q.ck, q.first_overflow_flag,
                                 q.first_overflow_irq_enable, q.compare_irq_enable};
               next_q.first_overflow_flag = 1'b0;
            end
            `ATRT_OFS_CNT1H: next_q.rd_data = {4'h0, q.hi_hold};
            `ATRT_OFS_CNT1L: begin
               next_q.rd_data = lo_byte(cnt1);
               next_q.hi_hold = cnt1[11:8];
            end
            `ATRT_OFS_RLD1H: next_q.rd_data = hi_byte(q.rld1);
            `ATRT_OFS_RLD1L: next_q.rd_data = lo_byte(q.rld1);
            `ATRT_OFS_RLD2H: next_q.rd_data = hi_byte(q.rld2);
            `ATRT_OFS_RLD2L: next_q.rd_data = lo_byte(q.rld2);
            `ATRT_OFS_OE: begin
               next_q.rd_data = {1'b0, q.oe[3], 1'b0, q.oe[2],
                                 1'b0, q.oe[1], 1'b0, q.oe[0]};
            end
            `ATRT_OFS_CAPH: begin
               next_q.rd_data = hi_byte(q.cap);
               next_q.capture_flag = 1'b0;
            end
            `ATRT_OFS_CAPL: begin
               next_q.rd_data = lo_byte(q.cap);
               next_q.capture_flag = 1'b0;
            end
            `ATRT_OFS_CSR2: begin
               next_q.rd_data = {2'b00, q.capture_source_select, q.second_overflow_irq_enable, q.second_overflow_flag,
                                 q.run2, q.second_transfer_enable, q.first_transfer_enable};
               next_q.second_overflow_flag = 1'b0;
            end
            `ATRT_OFS_BRK: begin
               next_q.rd_data = {2'b00, q.ba, q.break_pin_enable, q.pattern};
            end
            default: begin
            end
         endcase
         for (int i = 0; i < 4; i++) begin
            if (addr_i == `ATRT_OFS_CH0CSR + 6'(i)) begin
               next_q.rd_data = {6'h00, q.pol_pre[i], q.cmpf[i]};
               next_q.cmpf[i] = 1'b0;
            end
            if (addr_i == `ATRT_OFS_DUTY0H + 6'(2 * i)) begin
               next_q.rd_data = hi_byte(q.duty_pre[i]);
            end
            if (addr_i == `ATRT_OFS_DUTY0H + 6'(2 * i + 1)) begin
               next_q.rd_data = lo_byte(q.duty_pre[i]);
            end
         end
      end

      // Overflow flags; set wins over a same-cycle read clear
      if (wrap1) begin
         next_q.first_overflow_flag = 1'b1;
      end
      if (wrap2) begin
         next_q.second_overflow_flag = 1'b1;
      end

      // Compare on counter one only; two channels in dual mode, never zero
      for (int i = 0; i < 4; i++) begin
         if (tick1 && (next_cnt1 == q.duty_act[i]) &&
             (q.duty_act[i] != `ATRT_CNT_ZERO) && (i < 2 || !q.run2)) begin
            next_q.cmpf[i] = 1'b1;
         end
      end

      // Capture is inhibited while the previous one is unread
      if (cap_edge && !q.capture_flag) begin
         next_q.cap = cnt1;
         next_q.capture_flag = 1'b1;
      end

      // Preload to active transfers at overflow
      if (wrap1 && q.first_transfer_enable) begin
         for (int i = 0; i < 4; i++) begin
            if (i < 2 || !q.run2) begin
               next_q.duty_act[i] = q.duty_pre[i];
               next_q.pol_act[i] = q.pol_pre[i];
            end
         end
         next_q.first_transfer_enable = 1'b0;
      end
      if (wrap2 && q.second_transfer_enable) begin
         for (int i = 2; i < 4; i++) begin
            next_q.duty_act[i] = q.duty_pre[i];
            next_q.pol_act[i] = q.pol_pre[i];
         end
         next_q.second_transfer_enable = 1'b0;
      end

      // Break pin only counts while enabled
      if (q.break_pin_enable && !break_pin_b_i) begin
         next_q.ba = 1'b1;
      end

      // Break holds period, duty and enables at reset values
      if (q.ba) begin
         next_q.rld1 = `ATRT_CNT_ZERO;
         next_q.rld2 = `ATRT_CNT_ZERO;
         next_q.duty_pre = '0;
         next_q.duty_act = '0;
         next_q.oe = 4'h0;
      end

      // Pin drive; inversion sits before the break pattern
      for (int i = 0; i < 4; i++) begin
         next_q.pwm[i] = q.ba ? q.pattern[i] :
                         (level[i] ^ q.pol_act[i]);
         next_q.pwm_oe[i] = q.oe[i] | q.ba;
      end

      // Interrupt requests from the updated flags
      next_q.irq_cap_cmp = (next_q.capture_flag && next_q.capture_irq_enable) ||
                           ((|next_q.cmpf) && next_q.compare_irq_enable);
      next_q.irq_first_overflow_flag = next_q.first_overflow_flag && next_q.first_overflow_irq_enable;
      next_q.irq_second_overflow_flag = next_q.second_overflow_flag && next_q.second_overflow_irq_enable;
   end

   // Outputs come straight from the state register
   assign rd_data_o = q.rd_data;
   assign pwm_o = q.pwm;
   assign pwm_oe_o = q.pwm_oe;
   assign irq_capture_compare_o = q.irq_cap_cmp;
   assign irq_overflow_one_o = q.irq_first_overflow_flag;
   assign irq_overflow_two_o = q.irq_second_overflow_flag;

   // State register; both transfer enables come up set
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.second_transfer_enable <= 1'b1;
         q.first_transfer_enable <= 1'b1;
      end else if (ce_i) begin
         q <= next_q;
      end
   end
endmodule

// ### atrt_timer_asserts.sv
`timescale 1ns/1ps
`include "atrt_defines.svh"
module atrt_timer_asserts (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire atrt_pkg::atrt_addr_t addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire atrt_pkg::atrt_byte_t wr_data_i,
   input wire atrt_pkg::atrt_byte_t rd_data_o,
   input wire logic [3:0] pwm_oe_o,
   input wire logic irq_capture_compare_o,
   input wire logic irq_overflow_one_o,
   input wire logic irq_overflow_two_o
);
   import atrt_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Only strobes taken with the enable up count as accesses
   logic rd_ok;
   logic wr_ok;
   assign rd_ok = rd_i && ce_i;
   assign wr_ok = wr_i && ce_i;
   // Read data show the state before the read edge, as did the request
   // sampled at that edge; the request after it already sees the clear
   brk_rsv_a: assert property (
      $past(rd_ok && addr_i == `ATRT_OFS_BRK) |-> rd_data_o[7:6] == 2'h0)
      else $error("break top bits set");
   stat_two_rsv_a: assert property (
      $past(rd_ok && addr_i == `ATRT_OFS_CSR2) |-> rd_data_o[7:6] == 2'h0)
      else $error("status two top bits set");
   ovf_one_irq_a: assert property (
      $past(rd_ok && addr_i == `ATRT_OFS_CSR) |->
      $past(irq_overflow_one_o) == (rd_data_o[2] & rd_data_o[1]))
      else $error("overflow one request wrong");
   ovf_two_irq_a: assert property (
      $past(rd_ok && addr_i == `ATRT_OFS_CSR2) |->
      $past(irq_overflow_two_o) == (rd_data_o[4] & rd_data_o[3]))
      else $error("overflow two request wrong");
   cap_irq_a: assert property (
      $past(rd_ok && addr_i == `ATRT_OFS_CSR) && rd_data_o[6] &&
      rd_data_o[5] |-> irq_capture_compare_o)
      else $error("capture request missing");
   irq_mask_a: assert property (
      $past(rd_ok && addr_i == `ATRT_OFS_CSR) && !rd_data_o[5] &&
      !rd_data_o[0] |-> !irq_capture_compare_o)
      else $error("masked request raised");
   brk_force_a: assert property (
      wr_ok && addr_i == `ATRT_OFS_BRK && wr_data_i[5] |->
      ##[1:2] pwm_oe_o == 4'hf)
      else $error("break does not own pins");
   hi_rsv_a: assert property (
      $past(rd_ok && addr_i inside {`ATRT_OFS_CNT1H, `ATRT_OFS_CAPH}) |->
      rd_data_o[7:4] == 4'h0)
      else $error("high byte top nibble set");
   chan_rsv_a: assert property (
      $past(rd_ok && addr_i inside {[6'h13:6'h16]}) |->
      rd_data_o[7:2] == 6'h00)
      else $error("channel status top bits set");
endmodule
bind atrt_timer atrt_timer_asserts i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .ce_i(ce_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
   .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .pwm_oe_o(pwm_oe_o),
   .irq_capture_compare_o(irq_capture_compare_o),
   .irq_overflow_one_o(irq_overflow_one_o),
   .irq_overflow_two_o(irq_overflow_two_o));

// ### atrt_load_model.sv
`timescale 1ns/1ps
module atrt_load_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic own_lvl_i,
   input wire logic lite_lvl_i,
   input wire logic brk_low_i,
   output logic lite_timer_tick_o,
   output logic own_capture_pin_o,
   output logic lite_capture_pin_o,
   output logic break_pin_b_o
);
   logic [1:0] div;
   // Tick every fourth clock; pins change only just after an edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div <= 2'h0;
         lite_timer_tick_o <= 1'b0;
         own_capture_pin_o <= 1'b0;
         lite_capture_pin_o <= 1'b0;
         break_pin_b_o <= 1'b1;
      end else begin
         div <= div + 2'h1;
         lite_timer_tick_o <= (div == 2'h3);
         own_capture_pin_o <= own_lvl_i;
         lite_capture_pin_o <= lite_lvl_i;
         break_pin_b_o <= !brk_low_i;
      end
   end
endmodule

// ### atrt_timer_tb.sv
`timescale 1ns/1ps
`include "atrt_defines.svh"
module atrt_timer_tb;
   import atrt_pkg::*;
   logic clk_i;
   logic rst_b_i;
   atrt_addr_t addr_i;
   atrt_byte_t wr_data_i;
   logic wr_i;
   logic rd_i;
   logic ce;
   logic own_lvl;
   logic lite_lvl;
   logic brk_low;
   logic tick;
   logic own_pin;
   logic lite_pin;
   logic brk_pin_b;
   atrt_byte_t rd_data_o;
   logic [3:0] pwm_o;
   logic [3:0] pwm_oe_o;
   logic irq_cc;
   logic irq_o1;
   logic irq_o2;
   int compares;
   int miscompares;
   // Clock codes with overflow enable, and ticks seen in 16 cycles
   atrt_byte_t ck_code [4] = '{8'h12, 8'h0a, 8'h1a, 8'h02};
   atrt_byte_t ck_ticks [4] = '{8'h10, 8'h04, 8'h00, 8'h00};
   atrt_timer i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .lite_timer_tick_i(tick), .own_capture_pin_i(own_pin),
      .lite_capture_pin_i(lite_pin), .break_pin_b_i(brk_pin_b),
      .rd_data_o(rd_data_o), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
      .irq_capture_compare_o(irq_cc), .irq_overflow_one_o(irq_o1),
      .irq_overflow_two_o(irq_o2));
   atrt_load_model i_load (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .own_lvl_i(own_lvl), .lite_lvl_i(lite_lvl), .brk_low_i(brk_low),
      .lite_timer_tick_o(tick), .own_capture_pin_o(own_pin),
      .lite_capture_pin_o(lite_pin), .break_pin_b_o(brk_pin_b));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One-cycle strobes, launched just after an edge
   task wr8(input atrt_addr_t a, input atrt_byte_t d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd8(input atrt_addr_t a, output atrt_byte_t d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask
   task rchk(input atrt_addr_t a, input atrt_byte_t e, input string nm);
      atrt_byte_t v;
      rd8(a, v);
      chk(nm, {4'h0, v}, {4'h0, e});
   endtask
   // Two low-byte reads taken exactly 16 cycles apart
   task span(output atrt_byte_t d);
      atrt_byte_t a;
      atrt_byte_t b;
      rd8(`ATRT_OFS_CNT1L, a);
      idle(14);
      rd8(`ATRT_OFS_CNT1L, b);
      d = b - a;
   endtask
   // High time of channel zero over two periods of 16
   task hi_cnt(output logic [11:0] n);
      n = 12'h000;
      repeat (32) begin
         @(posedge clk_i);
         #1 if (pwm_o[0] === 1'b1) n++;
      end
   endtask
   task results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // A hang counts as a mismatch
   initial begin
      idle(20000);
      miscompares++;
      results();
   end
   initial begin
      atrt_byte_t v;
      atrt_byte_t e;
      logic [11:0] n;
      logic [11:0] d;
      {addr_i, wr_data_i, wr_i, rd_i, own_lvl, lite_lvl, brk_low} = '0;
      ce = 1'b1;
      rst_b_i = 1'b0;
      idle(12);
      rst_b_i <= 1'b1;
      for (int a = 13; a <= 37; a++) begin
         rchk(a[5:0], (a == 33) ? `ATRT_CSR2_RESET : 8'h00, "reset");
      end
      $display("test reset done");
      wr8(`ATRT_OFS_CSR2, 8'hff);
      rchk(`ATRT_OFS_CSR2, 8'h37, "status two");
      wr8(`ATRT_OFS_CSR2, 8'h03);
      wr8(`ATRT_OFS_BRK, 8'hdf);
      rchk(`ATRT_OFS_BRK, 8'h1f, "break");
      wr8(`ATRT_OFS_CSR, 8'h44);
      rchk(`ATRT_OFS_CSR, 8'h00, "status");
      wr8(`ATRT_OFS_CH0CSR, 8'h03);
      rchk(`ATRT_OFS_CH0CSR, 8'h02, "channel");
      wr8(`ATRT_OFS_CH0CSR, 8'h00);
      $display("test access done");
      wr8(`ATRT_OFS_BRK, 8'h25);
      idle(3);
      chk("pattern", {8'h00, pwm_o}, 12'h005);
      chk("pattern oe", {8'h00, pwm_oe_o}, 12'h00f);
      wr8(`ATRT_OFS_RLD1L, 8'h12);
      rchk(`ATRT_OFS_RLD1L, 8'h00, "reload");
      wr8(`ATRT_OFS_BRK, 8'h10);
      @(posedge clk_i) brk_low <= 1'b1;
      idle(3);
      rchk(`ATRT_OFS_BRK, 8'h30, "break pin");
      @(posedge clk_i) brk_low <= 1'b0;
      wr8(`ATRT_OFS_BRK, 8'h00);
      @(posedge clk_i) brk_low <= 1'b1;
      idle(3);
      rchk(`ATRT_OFS_BRK, 8'h00, "break off");
      @(posedge clk_i) brk_low <= 1'b0;
      $display("test break done");
      wr8(`ATRT_OFS_RLD1H, 8'h0f);
      wr8(`ATRT_OFS_RLD1L, 8'hf0);
      rchk(`ATRT_OFS_RLD1L, 8'hf0, "reload");
      wr8(`ATRT_OFS_DUTY0H, 8'h0f);
      wr8(`ATRT_OFS_DUTY0H + 6'h01, 8'hfc);
      wr8(`ATRT_OFS_OE, 8'h01);
      wr8(`ATRT_OFS_CSR2, 8'h17);
      idle(2);
      chk("enables", {8'h00, pwm_oe_o}, 12'h001);
      for (int i = 0; i < 4; i++) begin
         wr8(`ATRT_OFS_CSR, ck_code[i]);
         span(v);
         chk("ticks", {4'h0, v}, {4'h0, ck_ticks[i]});
      end
      $display("test clock done");
      wr8(`ATRT_OFS_CSR, 8'h12);
      idle(4300);
      hi_cnt(n);
      chk("high time", n, 12'h018);
      wr8(`ATRT_OFS_CH0CSR, 8'h02);
      wr8(`ATRT_OFS_CSR2, 8'h15);
      idle(40);
      hi_cnt(n);
      chk("inverted", n, 12'h008);
      rd8(`ATRT_OFS_CNT1L, v);
      rchk(`ATRT_OFS_CNT1H, 8'h0f, "held high");
      wr8(`ATRT_OFS_CSR, 8'h02);
      idle(2);
      chk("masked", {11'h000, irq_cc}, 12'h000);
      wr8(`ATRT_OFS_CSR, 8'h03);
      idle(2);
      chk("compare irq", {11'h000, irq_cc}, 12'h001);
      rchk(`ATRT_OFS_CH0CSR, 8'h03, "compare");
      rchk(`ATRT_OFS_CH0CSR, 8'h02, "compare");
      rchk(`ATRT_OFS_CSR, 8'h07, "overflow");
      rchk(`ATRT_OFS_CSR, 8'h03, "overflow");
      rchk(`ATRT_OFS_CSR2, 8'h1c, "second");
      rchk(`ATRT_OFS_CSR2, 8'h14, "second");
      $display("test counting done");
      rd8(`ATRT_OFS_CNT1L, v);
      d[7:0] = v;
      rd8(`ATRT_OFS_CNT1H, v);
      d[11:8] = v[3:0];
      @(posedge clk_i) own_lvl <= 1'b1;
      idle(4);
      rchk(`ATRT_OFS_CSR, 8'h43, "capture flag");
      wr8(`ATRT_OFS_CSR, 8'h10);
      wr8(`ATRT_OFS_CSR, 8'h00);
      rd8(`ATRT_OFS_CNT1L, e);
      @(posedge clk_i) own_lvl <= 1'b0;
      idle(4);
      rchk(`ATRT_OFS_CAPL, d[7:0], "capture");
      rchk(`ATRT_OFS_CAPH, {4'h0, d[11:8]}, "capture");
      rchk(`ATRT_OFS_CSR, 8'h00, "capture flag");
      @(posedge clk_i) lite_lvl <= 1'b1;
      idle(4);
      rchk(`ATRT_OFS_CSR, 8'h00, "own pin only");
      wr8(`ATRT_OFS_CSR2, 8'h20);
      // Source switch sees a level change; clear it so the real edge counts
      rchk(`ATRT_OFS_CAPL, e, "switch");
      wr8(`ATRT_OFS_CSR, 8'h20);
      @(posedge clk_i) lite_lvl <= 1'b0;
      idle(4);
      chk("capture irq", {11'h000, irq_cc}, 12'h001);
      rchk(`ATRT_OFS_CSR, 8'h60, "capture set");
      rchk(`ATRT_OFS_CAPL, e, "lite capture");
      $display("test capture done");
      // Eight edges with the enable low must not move counter one
      wr8(`ATRT_OFS_CSR, 8'h10);
      rd8(`ATRT_OFS_CNT1L, v);
      @(posedge clk_i) ce <= 1'b0;
      idle(8);
      ce <= 1'b1;
      rd8(`ATRT_OFS_CNT1L, e);
      chk("frozen", {8'h00, 4'(e - v)}, 12'h003);
      $display("test enable done");
      results();
   end
endmodule
